// ==== core/fee_pkg.sv ====
// Constants, types and helpers shared by the emulated byte-store controller.
// Assumes a byte-wide flash port whose page is 512 bytes.
package fee_pkg;
	localparam int unsigned PAGE_BYTES = 512;
	localparam int unsigned CTRL_BYTES = 9;
	localparam int unsigned DATA_BYTES = PAGE_BYTES - CTRL_BYTES;
	localparam logic [15:0] LEN_OFS = 16'h0000;
	localparam logic [15:0] MAP_OFS = 16'h0001;
	localparam logic [15:0] SLOT_OFS = 16'h0009;
	localparam logic [2:0] MAP_LAST = 3'h7;
	localparam logic [7:0] BLANK_BYTE = 8'hFF;
	localparam logic [7:0] LEN_MIN = 8'h07;
	localparam logic [7:0] LEN_MAX = 8'h0F;
	localparam logic [1:0] HDR_LAST = 2'h3;
	localparam int unsigned FIFO_WIDTH = 8;
	localparam int unsigned FIFO_DEPTH = 16;

	// Request kinds
	typedef enum logic {OP_STORE, OP_FETCH} fee_op_t;

	// One command to the flash page array
	typedef struct packed {
		logic rd;
		logic prog;
		logic erase;
		logic [15:0] addr;
		logic [7:0] wdata;
		logic [7:0] rate;
	} fee_flash_cmd_t;

	// Slots per page: record space divided by record length
	function automatic logic [6:0] slots_for(input logic [7:0] len);
		logic [15:0] q;
		q = 16'(DATA_BYTES) / ((len == 8'h00) ? 16'h0001 : {8'h00, len});
		return q[6:0];
	endfunction

	// Count programmed (zero) bits of one usage-map byte
	function automatic logic [3:0] zeros8(input logic [7:0] b);
		logic [3:0] n;
		n = 4'h0;
		for (int i = 0; i < 8; i++)
			n = n + {3'h0, ~b[i]};
		return n;
	endfunction
endpackage

// ==== core/fee_fifo.sv ====
// Parameterised synchronous FIFO with valid/ready on both sides.
// Assumes one clock; ready and empty are registered flags.
`timescale 1ns/1ps
module fee_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 16
)(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int unsigned AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0] cnt_q;
	logic ready_q;
	logic empty_q;
	wire push = in_valid && ready_q;
	wire pop = out_ready && !empty_q;
	wire [AW:0] cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

	// Handshake outputs
	assign in_ready = ready_q;
	assign out_valid = !empty_q;
	assign out_data = mem[rd_q];

	// Storage write
	always_ff @(posedge clk)
	begin
		if (ce && push)
			mem[wr_q] <= in_data;
	end

	// Pointers and flags
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
			ready_q <= 1'b1;
			empty_q <= 1'b1;
		end
		else if (ce)
		begin
			if (push)
				wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
			if (pop)
				rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
			cnt_q <= cnt_d;
			ready_q <= (cnt_d != (AW + 1)'(DEPTH));
			empty_q <= (cnt_d == '0);
		end
	end
endmodule

// ==== core/fee_store.sv ====
// Emulated byte-store controller: appends records to one flash page, fetches the last.
// Assumes a same-clock flash controller that pulses FL_DONE once per command.
// Functional notes
// - One whole 512-byte page is dedicated
// - Store appends record into next blank slot
// - Full page: erase, then restart at start
// - Nine-byte control area, 503 record bytes
// - 62 slots at 8 bytes, 33 at 15
// - Length mismatch store is ignored, flash untouched
// - Fetch returns the most recent record
// - Length mismatch fetch leaves data untouched
// - Address and length are not validated
// - Block order: rate, length, high, low, data
`timescale 1ns/1ps
module fee_store #(
	parameter int unsigned FIFO_W = fee_pkg::FIFO_WIDTH,
	parameter int unsigned FIFO_D = fee_pkg::FIFO_DEPTH
)(
	input wire logic MCLK,
	input wire logic RESET_N,
	input wire logic CE,
	input wire logic STORE_REQ,
	input wire logic FETCH_REQ,
	input wire logic [7:0] IN_DATA,
	input wire logic IN_VALID,
	output logic IN_READY,
	output logic BUSY,
	output logic DONE,
	output logic IGNORED,
	output logic [7:0] FETCH_DATA,
	output logic FETCH_VALID,
	output fee_pkg::fee_flash_cmd_t FL_CMD,
	input wire logic [7:0] FL_RDATA,
	input wire logic FL_DONE
);
	import fee_pkg::*;
	typedef enum logic [3:0] {S_IDLE, S_HDR, S_RDLEN, S_RDMAP, S_CHECK, S_ERASE, S_WRLEN,
		S_WRDATA, S_WRMAP, S_RDDATA, S_DRAIN, S_FINISH} fee_state_t;
	fee_state_t state_q;
	fee_op_t op_q;
	fee_flash_cmd_t cmd_q;
	logic wait_q, blank_q, done_q, ign_q, fvalid_q, busy_q, fifo_valid, fifo_pop;
	logic [1:0] hdr_q;
	logic [7:0] rate_q, len_q, idx_q, fdata_q, fifo_data;
	logic [15:0] page_q;
	logic [6:0] used_q;
	logic [2:0] map_q;
	// Slot arithmetic; the 64-bit usage map also caps the slot count of short records
	wire [6:0] slots = slots_for(len_q);
	wire page_full = (used_q >= slots) || used_q[6];
	wire [15:0] used_bytes = {9'h000, used_q} * {8'h00, len_q};
	wire [15:0] last_bytes = {9'h000, used_q - 7'h01} * {8'h00, len_q};
	wire [15:0] next_slot_addr = page_q + SLOT_OFS + used_bytes + {8'h00, idx_q};
	wire [15:0] last_slot_addr = page_q + SLOT_OFS + last_bytes + {8'h00, idx_q};
	wire [15:0] map_wr_addr = page_q + MAP_OFS + {12'h000, used_q[6:3]};
	wire [7:0] map_wr_data = ~(8'h01 << used_q[2:0]);
	wire [15:0] map_rd_addr = page_q + MAP_OFS + {13'h0000, map_q};
	wire rec_last = (idx_q == len_q - 8'h01);
	wire len_mismatch = (FL_RDATA != BLANK_BYTE) && (FL_RDATA != len_q);
	wire got = wait_q && FL_DONE;
	// Byte stream buffer holding the parameter block
	assign fifo_pop = fifo_valid && !wait_q &&
		((state_q == S_HDR) || (state_q == S_WRDATA) || (state_q == S_DRAIN));
	fee_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_D)) i_fee_fifo (.clk(MCLK), .rst_n(RESET_N),
		.ce(CE), .in_data(IN_DATA), .in_valid(IN_VALID), .in_ready(IN_READY),
		.out_data(fifo_data), .out_valid(fifo_valid), .out_ready(fifo_pop));
	// Registered outputs
	assign BUSY = busy_q;
	assign DONE = done_q;
	assign IGNORED = ign_q;
	assign FETCH_DATA = fdata_q;
	assign FETCH_VALID = fvalid_q;
	assign FL_CMD = cmd_q;
	// Sequencer: header, control area scan, then program/erase or read back
	always_ff @(posedge MCLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			state_q <= S_IDLE;
			busy_q <= 1'b0;
			op_q <= OP_STORE;
			cmd_q <= '0;
			wait_q <= 1'b0;
			hdr_q <= 2'h0;
			rate_q <= 8'h00;
			len_q <= 8'h00;
			page_q <= 16'h0000;
			blank_q <= 1'b1;
			used_q <= 7'h00;
			map_q <= 3'h0;
			idx_q <= 8'h00;
			done_q <= 1'b0;
			ign_q <= 1'b0;
			fdata_q <= 8'h00;
			fvalid_q <= 1'b0;
		end
		else if (CE)
		begin
			cmd_q.rd <= 1'b0;
			cmd_q.prog <= 1'b0;
			cmd_q.erase <= 1'b0;
			cmd_q.rate <= rate_q;
			done_q <= 1'b0;
			fvalid_q <= 1'b0;
			if (got)
				wait_q <= 1'b0;
			case (state_q)
				S_IDLE:
				begin
					ign_q <= 1'b0;
					hdr_q <= 2'h0;
					if (STORE_REQ || FETCH_REQ)
					begin
						op_q <= STORE_REQ ? OP_STORE : OP_FETCH;
						busy_q <= 1'b1;
						state_q <= S_HDR;
					end
				end
				S_HDR:
				begin
					if (fifo_pop)
					begin
						hdr_q <= hdr_q + 2'h1;
						case (hdr_q)
							2'h0: rate_q <= fifo_data;
							2'h1: len_q <= fifo_data;
							2'h2: page_q[15:8] <= fifo_data;
							default: page_q[7:0] <= fifo_data;
						endcase
						if (hdr_q == HDR_LAST)
						begin
							cmd_q.rd <= 1'b1;
							cmd_q.addr <= {page_q[15:8], fifo_data} + LEN_OFS;
							wait_q <= 1'b1;
							state_q <= S_RDLEN;
						end
					end
				end
				S_RDLEN:
				begin
					if (got)
					begin
						blank_q <= (FL_RDATA == BLANK_BYTE);
						used_q <= 7'h00;
						map_q <= 3'h0;
						idx_q <= 8'h00;
						if (len_mismatch)
						begin
							ign_q <= 1'b1;
							state_q <= (op_q == OP_STORE) ? S_DRAIN : S_FINISH;
						end
						else
						begin
							cmd_q.rd <= 1'b1;
							cmd_q.addr <= page_q + MAP_OFS;
							wait_q <= 1'b1;
							state_q <= S_RDMAP;
						end
					end
				end
				S_RDMAP:
				begin
					if (got)
					begin
						used_q <= used_q + {3'h0, zeros8(FL_RDATA)};
						if (map_q == MAP_LAST)
							state_q <= S_CHECK;
						else
						begin
							map_q <= map_q + 3'h1;
							cmd_q.rd <= 1'b1;
							cmd_q.addr <= map_rd_addr + 16'h0001;
							wait_q <= 1'b1;
						end
					end
				end
				S_CHECK:
				begin
					if (op_q == OP_FETCH)
					begin
						if (used_q == 7'h00)
						begin
							ign_q <= 1'b1;
							state_q <= S_FINISH;
						end
						else
						begin
							cmd_q.rd <= 1'b1;
							cmd_q.addr <= last_slot_addr;
							wait_q <= 1'b1;
							state_q <= S_RDDATA;
						end
					end
					else if (page_full)
					begin
						cmd_q.erase <= 1'b1;
						cmd_q.addr <= page_q;
						wait_q <= 1'b1;
						state_q <= S_ERASE;
					end
					else if (blank_q)
					begin
						cmd_q.prog <= 1'b1;
						cmd_q.addr <= page_q + LEN_OFS;
						cmd_q.wdata <= len_q;
						wait_q <= 1'b1;
						state_q <= S_WRLEN;
					end
					else
						state_q <= S_WRDATA;
				end
				S_ERASE:
				begin
					if (got)
					begin
						used_q <= 7'h00;
						blank_q <= 1'b1;
						state_q <= S_CHECK;
					end
				end
				S_WRLEN:
					if (got)
						state_q <= S_WRDATA;
				S_WRDATA:
				begin
					if (fifo_pop)
					begin
						cmd_q.prog <= 1'b1;
						cmd_q.addr <= next_slot_addr;
						cmd_q.wdata <= fifo_data;
						wait_q <= 1'b1;
					end
					else if (got)
					begin
						if (rec_last)
						begin
							cmd_q.prog <= 1'b1;
							cmd_q.addr <= map_wr_addr;
							cmd_q.wdata <= map_wr_data;
							wait_q <= 1'b1;
							state_q <= S_WRMAP;
						end
						else
							idx_q <= idx_q + 8'h01;
					end
				end
				S_WRMAP:
					if (got)
						state_q <= S_FINISH;
				S_RDDATA:
				begin
					if (got)
					begin
						fdata_q <= FL_RDATA;
						fvalid_q <= 1'b1;
						if (rec_last)
							state_q <= S_FINISH;
						else
						begin
							idx_q <= idx_q + 8'h01;
							cmd_q.rd <= 1'b1;
							cmd_q.addr <= last_slot_addr + 16'h0001;
							wait_q <= 1'b1;
						end
					end
				end
				S_DRAIN:
				begin
					if (fifo_pop)
					begin
						idx_q <= idx_q + 8'h01;
						if (rec_last)
							state_q <= S_FINISH;
					end
				end
				S_FINISH:
				begin
					done_q <= 1'b1;
					busy_q <= 1'b0;
					state_q <= S_IDLE;
				end
				default:
				begin
					busy_q <= 1'b0;
					state_q <= S_IDLE;
				end
			endcase
		end
	end
endmodule

// ==== bench/fee_flash_model.sv ====
// Behavioural flash page array facing the store controller.
// Assumes one 512-byte page; upper address bits are not decoded.
`timescale 1ns/1ps
module fee_flash_model
	import fee_pkg::*;
(
	input wire logic clk,
	input wire logic slow,
	input wire fee_flash_cmd_t cmd,
	output logic [7:0] rdata,
	output logic done,
	output int n_erase
);
	logic [7:0] mem [PAGE_BYTES];
	fee_flash_cmd_t c;
	// Take one command, apply it, answer after a short or long wait
	initial
	begin
		foreach (mem[i])
			mem[i] = BLANK_BYTE;
		done = 1'b0;
		rdata = 8'h00;
		n_erase = 0;
		forever
		begin
			@(posedge clk);
			if (cmd.rd || cmd.prog || cmd.erase)
			begin
				c = cmd;
				if (c.erase)
				begin
					foreach (mem[i])
						mem[i] = BLANK_BYTE;
					n_erase++;
				end
				if (c.prog)
					mem[c.addr[8:0]] &= c.wdata; // Programming clears bits only
				repeat (slow ? 3 : 0) @(posedge clk);
				done <= 1'b1;
				rdata <= mem[c.addr[8:0]];
				@(posedge clk);
				done <= 1'b0;
				rdata <= ~mem[c.addr[8:0]]; // Stale data shown inverted
			end
		end
	end
endmodule

// ==== bench/fee_store_checker.sv ====
// Port assertions for the store controller.
// Assumes CE stays high while a request runs.
`timescale 1ns/1ps
module fee_store_checker
	import fee_pkg::*;
(
	input wire logic MCLK,
	input wire logic RESET_N,
	input wire logic CE,
	input wire logic STORE_REQ,
	input wire logic FETCH_REQ,
	input wire logic BUSY,
	input wire logic DONE,
	input wire logic IGNORED,
	input wire logic FETCH_VALID,
	input wire fee_flash_cmd_t FL_CMD,
	input wire logic FL_DONE
);
	logic seen_q;
	default clocking @(posedge MCLK); endclocking
	default disable iff (!RESET_N);
	// Flash writes or fetched bytes since the request was taken
	always_ff @(posedge MCLK or negedge RESET_N)
		if (!RESET_N)
			seen_q <= 1'b0;
		else if (CE && !BUSY)
			seen_q <= 1'b0;
		else if (FL_CMD.prog || FL_CMD.erase || FETCH_VALID)
			seen_q <= 1'b1;
	AST_TAKE: assert property (CE && !BUSY && (STORE_REQ || FETCH_REQ) |=> BUSY)
		else $error("request not taken");
	AST_CE_FREEZE: assert property (!CE && !BUSY |=> !BUSY)
		else $error("request taken while frozen");
	AST_END: assert property (DONE && CE |=> !BUSY && !DONE)
		else $error("busy or done after done");
	AST_DONE_BUSY: assert property (DONE |-> !BUSY)
		else $error("busy during done");
	AST_ONE_CMD: assert property ($onehot0({FL_CMD.rd, FL_CMD.prog, FL_CMD.erase}))
		else $error("two flash commands at once");
	AST_IDLE: assert property (!BUSY |-> !(FL_CMD.rd || FL_CMD.prog || FL_CMD.erase))
		else $error("flash command while idle");
	AST_ERASE: assert property (FL_CMD.erase |-> FL_CMD.addr[8:0] == 9'h000)
		else $error("erase not at page start");
	AST_MAP: assert property (FL_CMD.prog && FL_CMD.addr[8:0] inside {[9'h001:9'h008]}
		|-> $onehot(~FL_CMD.wdata))
		else $error("map write clears not one bit");
	AST_FV: assert property (FETCH_VALID |-> $past(FL_DONE) && BUSY)
		else $error("fetched byte without flash answer");
	AST_IGN: assert property (DONE && IGNORED |-> !seen_q && !FETCH_VALID)
		else $error("ignored request had effect");
endmodule
bind fee_store fee_store_checker i_fee_store_checker (.MCLK(MCLK), .RESET_N(RESET_N),
	.CE(CE), .STORE_REQ(STORE_REQ), .FETCH_REQ(FETCH_REQ), .BUSY(BUSY), .DONE(DONE),
	.IGNORED(IGNORED), .FETCH_VALID(FETCH_VALID), .FL_CMD(FL_CMD), .FL_DONE(FL_DONE));

// ==== bench/tb_fee_store.sv ====
// Self-checking bench for the store controller with a flash model.
// Assumes the bound checker and the flash model beside the design.
`timescale 1ns/1ps
module tb_fee_store;
	import fee_pkg::*;
	typedef struct {logic op; logic [7:0] len; logic [7:0] seed; logic ign;} fee_row_t;
	localparam logic [7:0] RATE = 8'hFF; // Four times 250 MHz saturates a byte
	localparam logic [15:0] PAGE = 16'hEE00;
	logic MCLK = 0, RESET_N = 0, CE = 1, STORE_REQ = 0, FETCH_REQ = 0, IN_VALID = 0, slow = 0;
	logic [7:0] IN_DATA = 8'h00;
	logic IN_READY, BUSY, DONE, IGNORED, FETCH_VALID, FL_DONE, ign_s, done_s;
	logic [7:0] FETCH_DATA, FL_RDATA;
	fee_flash_cmd_t FL_CMD;
	int n_fail = 0, check_count = 0, n_erase, e0;
	logic [7:0] got [$];
	fee_row_t rows [6] = '{'{1'b0, 8'h08, 8'h10, 1'b0}, '{1'b0, 8'h08, 8'h20, 1'b0},
		'{1'b1, 8'h08, 8'h20, 1'b0}, '{1'b0, 8'h0F, 8'h30, 1'b1},
		'{1'b1, 8'h0F, 8'h00, 1'b1}, '{1'b1, 8'h08, 8'h20, 1'b0}};
	fee_store i_fee_store (.MCLK(MCLK), .RESET_N(RESET_N), .CE(CE), .STORE_REQ(STORE_REQ),
		.FETCH_REQ(FETCH_REQ), .IN_DATA(IN_DATA), .IN_VALID(IN_VALID), .IN_READY(IN_READY),
		.BUSY(BUSY), .DONE(DONE), .IGNORED(IGNORED), .FETCH_DATA(FETCH_DATA),
		.FETCH_VALID(FETCH_VALID), .FL_CMD(FL_CMD), .FL_RDATA(FL_RDATA), .FL_DONE(FL_DONE));
	fee_flash_model i_fee_flash_model (.clk(MCLK), .slow(slow), .cmd(FL_CMD),
		.rdata(FL_RDATA), .done(FL_DONE), .n_erase(n_erase));
	always #2 MCLK = ~MCLK;
	// Collect fetched bytes and the end of each request
	always @(negedge MCLK)
	begin
		if (FETCH_VALID === 1'b1)
			got.push_back(FETCH_DATA);
		if (DONE === 1'b1)
		begin
			done_s = 1'b1;
			ign_s = IGNORED;
		end
	end
	task chk(input logic ok, input string msg);
		check_count++;
		if (ok !== 1'b1)
		begin
			n_fail++;
			$display("wrong value at %0t: %s", $time, msg);
		end
	endtask
	task push(input logic [7:0] b);
		logic r;
		IN_DATA = b;
		IN_VALID = 1'b1;
		do
		begin
			r = IN_READY;
			@(negedge MCLK);
		end
		while (!r);
	endtask
	task run(input fee_row_t r);
		done_s = 1'b0;
		got.delete();
		@(negedge MCLK);
		STORE_REQ = !r.op;
		FETCH_REQ = r.op;
		@(negedge MCLK);
		STORE_REQ = 1'b0;
		FETCH_REQ = 1'b0;
		push(RATE);
		push(r.len);
		push(PAGE[15:8]);
		push(PAGE[7:0]);
		for (int i = 0; i < r.len && !r.op; i++)
			push(r.seed + 8'(i));
		IN_VALID = 1'b0;
		for (int i = 0; i < 3000 && !done_s; i++)
			@(negedge MCLK);
		chk(done_s === 1'b1 && ign_s === r.ign, "done or ignore flag");
		chk(FL_CMD.rate === RATE, "rate byte");
		if (r.op && !r.ign)
			chk(got.size() == r.len, "fetched byte count");
		foreach (got[i])
			chk(!r.ign && got[i] === r.seed + 8'(i), "fetched byte");
	endtask
	task fill(input logic [7:0] len, input int n);
		e0 = n_erase;
		for (int i = 0; i < PAGE_BYTES; i++)
			i_fee_flash_model.mem[i] = BLANK_BYTE;
		for (int k = 0; k < n; k++)
			run('{1'b0, len, 8'(k), 1'b0});
		chk(n_erase == e0, "erase too early");
		run('{1'b0, len, 8'h5A, 1'b0});
		chk(n_erase == e0 + 1, "no erase on full page");
		run('{1'b1, len, 8'h5A, 1'b0});
		$display("fill test done");
	endtask
	task test_done;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Cut a hang short
	initial
	begin
		#200000;
		n_fail++;
		test_done;
	end
	// Main sequence
	initial
	begin
		repeat (12) @(negedge MCLK);
		chk(BUSY === 1'b0 && IN_READY === 1'b1 && FL_CMD === '0, "reset outputs");
		RESET_N = 1'b1;
		foreach (rows[i])
			run(rows[i]);
		$display("table test done");
		CE = 1'b0;
		STORE_REQ = 1'b1;
		@(negedge MCLK);
		STORE_REQ = 1'b0;
		repeat (2) @(negedge MCLK);
		chk(BUSY === 1'b0, "request taken while frozen");
		CE = 1'b1;
		slow = 1'b1;
		run('{1'b0, 8'h08, 8'h77, 1'b0});
		slow = 1'b0;
		$display("freeze test done");
		fill(8'h08, 62);
		RESET_N = 1'b0;
		@(negedge MCLK);
		chk(BUSY === 1'b0 && DONE === 1'b0, "outputs in reset");
		RESET_N = 1'b1;
		run('{1'b1, 8'h08, 8'h5A, 1'b0});
		$display("reset test done");
		fill(8'h0F, 33);
		// Eight usage-map bytes hold 64 slots, so seven-byte records erase after 64
		fill(LEN_MIN, 64);
		test_done;
	end
endmodule
